// ===== hw/ssir_pkg.sv
// Shared constants, register map and carrier types of the servo sync interrupt registers
package ssir_pkg;

    // ==========================================================
    // Bus geometry
    localparam int unsigned ADDR_WIDTH = 20;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned REG_WIDTH = 8;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_VERT_THRESHOLD = 16'hd0b0;
    localparam logic [15:0] IDX_HORZ_THRESHOLD = 16'hd0b1;
    localparam logic [15:0] IDX_HPULSE_START = 16'hd0b2;
    localparam logic [15:0] IDX_HPULSE_WIDTH = 16'hd0b3;
    localparam logic [15:0] IDX_NOISE_WINDOW = 16'hd0b4;
    localparam logic [15:0] IDX_NOISE_VALUE = 16'hd0b5;
    localparam logic [15:0] IDX_ENABLE_TWO = 16'hd0b9;
    localparam logic [15:0] IDX_REQUEST_TWO = 16'hd0bb;

    // ==========================================================
    // Setting bank layout
    localparam int unsigned SETTING_COUNT = 6;
    localparam int unsigned SEL_WIDTH = 3;
    localparam logic [2:0] SEL_VERT_THRESHOLD = 3'h0;
    localparam logic [2:0] SEL_HORZ_THRESHOLD = 3'h1;
    localparam logic [2:0] SEL_HPULSE_START = 3'h2;
    localparam logic [2:0] SEL_HPULSE_WIDTH = 3'h3;
    localparam logic [2:0] SEL_NOISE_WINDOW = 3'h4;
    localparam logic [2:0] SEL_NOISE_VALUE = 3'h5;
    localparam logic [7:0] MASK_VERT_THRESHOLD = 8'h3f;
    localparam logic [7:0] MASK_HORZ_THRESHOLD = 8'h0f;
    localparam logic [7:0] MASK_HPULSE_START = 8'hff;
    localparam logic [7:0] MASK_HPULSE_WIDTH = 8'h0f;
    localparam logic [7:0] MASK_NOISE_WINDOW = 8'h3f;
    localparam logic [7:0] MASK_NOISE_VALUE = 8'hff;
    localparam logic [7:0] SETTING_RESET = 8'h00;

    // ==========================================================
    // Interrupt register layout and read values
    localparam int unsigned BIT_CTL = 0;
    localparam int unsigned BIT_VSYNC = 1;
    localparam logic [7:0] RESERVED_ONES_TWO = 8'hfc;
    localparam logic [1:0] PAIR_RESET = 2'h0;
    localparam logic [7:0] WRITE_ONLY_READ = 8'h00;
    localparam logic [31:0] READ_RESET = 32'h0000_0000;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [5:0] vert_threshold;
        logic [3:0] horz_threshold;
        logic [7:0] hpulse_start;
        logic [3:0] hpulse_width;
        logic [5:0] noise_window;
        logic [7:0] noise_value;
    } ssir_settings_type;

    // Bit 1 vertical sync, bit 0 CTL, as in the register
    typedef struct packed {
        logic vsync;
        logic ctl;
    } ssir_pair_type;

    // ==========================================================
    // Helpers
    function automatic logic [ADDR_WIDTH-1:0] reg_addr(input logic [15:0] idx);
        return ADDR_WIDTH'({idx, 2'b00});
    endfunction

    function automatic logic [7:0] setting_mask(input logic [2:0] sel);
        case (sel)
            SEL_VERT_THRESHOLD: return MASK_VERT_THRESHOLD;
            SEL_HORZ_THRESHOLD: return MASK_HORZ_THRESHOLD;
            SEL_HPULSE_START: return MASK_HPULSE_START;
            SEL_HPULSE_WIDTH: return MASK_HPULSE_WIDTH;
            SEL_NOISE_WINDOW: return MASK_NOISE_WINDOW;
            default: return MASK_NOISE_VALUE;
        endcase
    endfunction

endpackage

// ===== hw/ssir_setting_bank.sv
// Write-only setting store of the sync detector, read out as registered fields
`timescale 1ns/1ps
`default_nettype none
module ssir_setting_bank (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [2:0] wr_sel_in,
    input wire logic [7:0] wr_data_in,
    // Settings to the detector
    output var ssir_pkg::ssir_settings_type settings_out
);

    // ==========================================================
    // Storage
    logic [7:0] mem [ssir_pkg::SETTING_COUNT];
    logic [7:0] next_mem [ssir_pkg::SETTING_COUNT];

    always_comb begin
        for (int i = 0; i < ssir_pkg::SETTING_COUNT; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr_en_in) begin
            // Unimplemented high bits are never stored
            next_mem[wr_sel_in] = wr_data_in & ssir_pkg::setting_mask(wr_sel_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < ssir_pkg::SETTING_COUNT; i++) begin
                mem[i] <= ssir_pkg::SETTING_RESET;
            end
        end else begin
            for (int i = 0; i < ssir_pkg::SETTING_COUNT; i++) begin
                mem[i] <= next_mem[i];
            end
        end
    end

    // ==========================================================
    // Field outputs
    assign settings_out.vert_threshold = mem[ssir_pkg::SEL_VERT_THRESHOLD][5:0];
    assign settings_out.horz_threshold = mem[ssir_pkg::SEL_HORZ_THRESHOLD][3:0];
    assign settings_out.hpulse_start = mem[ssir_pkg::SEL_HPULSE_START];
    assign settings_out.hpulse_width = mem[ssir_pkg::SEL_HPULSE_WIDTH][3:0];
    assign settings_out.noise_window = mem[ssir_pkg::SEL_NOISE_WINDOW][5:0];
    assign settings_out.noise_value = mem[ssir_pkg::SEL_NOISE_VALUE];

endmodule
`default_nettype wire

// ===== hw/ssir_regs.sv
// APB register block of the servo sync detector settings and servo interrupt flags
// Notes on behaviour
// - Vertical sync enable bit 1 passes its flag to the request when 1, blocks at 0.
// - Vertical sync flag is set by a detector vertical drive pulse or noise event.
// - CTL flag at bit 0 is set whenever a CTL interrupt event arrives.
// - Flags clear only by writing 0; writing 1 keeps them; set flags persist.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ssir_regs #(
    parameter int unsigned ADDR_WIDTH = ssir_pkg::ADDR_WIDTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_WIDTH-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Events from the sync detector and CTL logic
    input wire logic vertical_drive_pulse_in,
    input wire logic noise_event_in,
    input wire logic ctl_event_in,
    // Settings to the sync detector
    output var ssir_pkg::ssir_settings_type settings_out,
    // Servo interrupt request
    output logic servo_irq_out
);

    // ==========================================================
    // Address decode
    typedef enum logic [3:0] {
        SSIR_HIT_NONE = 4'h0,
        SSIR_HIT_SETTING = 4'h1,
        SSIR_HIT_ENABLE = 4'h3,
        SSIR_HIT_REQUEST = 4'h2
    } ssir_hit_type;

    function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] addr, input logic [15:0] idx);
        return addr == ADDR_WIDTH'(ssir_pkg::reg_addr(idx));
    endfunction

    // Interrupt registers read their reserved bits as ones above the pair
    function automatic logic [31:0] pair_read(input ssir_pkg::ssir_pair_type pair);
        return {24'h00_0000, ssir_pkg::RESERVED_ONES_TWO[7:2], pair};
    endfunction

    // A written 0 clears a flag, a written 1 leaves it as it stands
    function automatic logic clear_by_zero(input logic flag, input logic wr_bit);
        return flag & wr_bit;
    endfunction

    ssir_hit_type hit;
    logic [2:0] setting_sel;

    always_comb begin
        hit = SSIR_HIT_SETTING;
        setting_sel = ssir_pkg::SEL_VERT_THRESHOLD;
        if (addr_is(paddr_in, ssir_pkg::IDX_VERT_THRESHOLD)) begin
            setting_sel = ssir_pkg::SEL_VERT_THRESHOLD;
        end else if (addr_is(paddr_in, ssir_pkg::IDX_HORZ_THRESHOLD)) begin
            setting_sel = ssir_pkg::SEL_HORZ_THRESHOLD;
        end else if (addr_is(paddr_in, ssir_pkg::IDX_HPULSE_START)) begin
            setting_sel = ssir_pkg::SEL_HPULSE_START;
        end else if (addr_is(paddr_in, ssir_pkg::IDX_HPULSE_WIDTH)) begin
            setting_sel = ssir_pkg::SEL_HPULSE_WIDTH;
        end else if (addr_is(paddr_in, ssir_pkg::IDX_NOISE_WINDOW)) begin
            setting_sel = ssir_pkg::SEL_NOISE_WINDOW;
        end else if (addr_is(paddr_in, ssir_pkg::IDX_NOISE_VALUE)) begin
            setting_sel = ssir_pkg::SEL_NOISE_VALUE;
        end else if (addr_is(paddr_in, ssir_pkg::IDX_ENABLE_TWO)) begin
            hit = SSIR_HIT_ENABLE;
        end else if (addr_is(paddr_in, ssir_pkg::IDX_REQUEST_TWO)) begin
            hit = SSIR_HIT_REQUEST;
        end else begin
            hit = SSIR_HIT_NONE;
        end
    end

    // ==========================================================
    // Bus phases
    logic setup_phase;
    logic write_commit;
    logic setting_write;
    logic enable_write;
    logic request_write;

    // Every access ends in its first access cycle
    assign pready_out = psel_in & penable_in;
    assign setup_phase = psel_in & ~penable_in;
    assign write_commit = psel_in & penable_in & pwrite_in & (hit != SSIR_HIT_NONE);
    assign setting_write = write_commit & (hit == SSIR_HIT_SETTING);
    assign enable_write = write_commit & (hit == SSIR_HIT_ENABLE);
    assign request_write = write_commit & (hit == SSIR_HIT_REQUEST);

    // ==========================================================
    // Setting bank
    ssir_setting_bank u_setting_bank (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(setting_write),
        .wr_sel_in(setting_sel),
        .wr_data_in(pwdata_in[7:0]),
        .settings_out(settings_out)
    );

    // ==========================================================
    // Interrupt enables and flags
    ssir_pkg::ssir_pair_type irq_enable;
    ssir_pkg::ssir_pair_type next_irq_enable;
    ssir_pkg::ssir_pair_type irq_flag;
    ssir_pkg::ssir_pair_type next_irq_flag;
    ssir_pkg::ssir_pair_type flag_set;
    ssir_pkg::ssir_pair_type flag_keep;

    always_comb begin
        next_irq_enable = irq_enable;
        if (enable_write) begin
            next_irq_enable.vsync = pwdata_in[ssir_pkg::BIT_VSYNC];
            next_irq_enable.ctl = pwdata_in[ssir_pkg::BIT_CTL];
        end
    end

    always_comb begin
        flag_set.vsync = vertical_drive_pulse_in | noise_event_in;
        flag_set.ctl = ctl_event_in;
        flag_keep = irq_flag;
        if (request_write) begin
            // Writing 0 clears, writing 1 leaves the flag alone
            flag_keep.vsync = clear_by_zero(irq_flag.vsync,
                                            pwdata_in[ssir_pkg::BIT_VSYNC]);
            flag_keep.ctl = clear_by_zero(irq_flag.ctl,
                                          pwdata_in[ssir_pkg::BIT_CTL]);
        end
        // A new event wins over a clear in the same cycle
        next_irq_flag = flag_keep | flag_set;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_enable <= ssir_pkg::PAIR_RESET;
        end else begin
            irq_enable <= next_irq_enable;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_flag <= ssir_pkg::PAIR_RESET;
        end else begin
            irq_flag <= next_irq_flag;
        end
    end

    // ==========================================================
    // Interrupt output
    logic irq_line;
    logic next_irq_line;

    always_comb begin
        next_irq_line = (next_irq_flag.vsync & next_irq_enable.vsync) |
                        (next_irq_flag.ctl & next_irq_enable.ctl);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_line <= 1'b0;
        end else begin
            irq_line <= next_irq_line;
        end
    end

    assign servo_irq_out = irq_line;

    // ==========================================================
    // Read data and error, captured in the setup cycle
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic slverr;
    logic next_slverr;

    always_comb begin
        next_rdata = rdata;
        next_slverr = slverr;
        if (setup_phase) begin
            next_slverr = (hit == SSIR_HIT_NONE);
            case (hit)
                SSIR_HIT_SETTING: begin
                    next_rdata = {24'h00_0000, ssir_pkg::WRITE_ONLY_READ};
                end
                SSIR_HIT_ENABLE: begin
                    next_rdata = pair_read(irq_enable);
                end
                SSIR_HIT_REQUEST: begin
                    next_rdata = pair_read(irq_flag);
                end
                default: begin
                    next_rdata = ssir_pkg::READ_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata <= ssir_pkg::READ_RESET;
            slverr <= 1'b0;
        end else begin
            rdata <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign prdata_out = rdata;
    assign pslverr_out = slverr & psel_in & penable_in;

endmodule
`default_nettype wire

// ===== verification/ssir_regs_chk.sv
// Concurrent checks of the servo interrupt flags, enables and request output
`timescale 1ns/1ps
`default_nettype none
module ssir_regs_chk #(
    parameter int unsigned ADDR_WIDTH = ssir_pkg::ADDR_WIDTH
) (
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_WIDTH-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    // Events and request
    input wire logic vertical_drive_pulse_in,
    input wire logic noise_event_in,
    input wire logic ctl_event_in,
    input wire logic servo_irq_out
);
    // ==========================================================
    // Shadow of enables and flags
    logic [1:0] en_m, fl_m, next_en_m, next_fl_m;
    logic wr_en, wr_req;
    always_comb begin
        wr_en = psel_in && penable_in && pwrite_in
            && paddr_in == ADDR_WIDTH'({ssir_pkg::IDX_ENABLE_TWO, 2'b00});
        wr_req = psel_in && penable_in && pwrite_in
            && paddr_in == ADDR_WIDTH'({ssir_pkg::IDX_REQUEST_TWO, 2'b00});
        next_en_m = wr_en ? pwdata_in[1:0] : en_m;
        next_fl_m = wr_req ? (fl_m & pwdata_in[1:0]) : fl_m;
        next_fl_m = next_fl_m | {vertical_drive_pulse_in | noise_event_in, ctl_event_in};
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_m <= 2'h0;
            fl_m <= 2'h0;
        end else begin
            en_m <= next_en_m;
            fl_m <= next_fl_m;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_ctl_hit;
        ctl_event_in && en_m[0] && !wr_en;
    endsequence
    sequence s_vsync_hit;
        (vertical_drive_pulse_in || noise_event_in) && en_m[1] && !wr_en;
    endsequence
    a_irq_tracks_flags: assert property (servo_irq_out == |(fl_m & en_m))
        else $error("request output differs from flags and enables");
    a_ctl_raises_irq: assert property (s_ctl_hit |=> servo_irq_out)
        else $error("enabled CTL event gave no request");
    a_vsync_raises_irq: assert property (s_vsync_hit |=> servo_irq_out)
        else $error("enabled vertical sync event gave no request");
    a_mask_blocks_irq: assert property (en_m == 2'h0 && !wr_en |=> !servo_irq_out)
        else $error("request raised with both enables clear");
    a_flag_persists: assert property ($fell(servo_irq_out) |-> $past(wr_en || wr_req))
        else $error("request fell without a register write");
    a_zero_wait: assert property (psel_in && penable_in |-> pready_out)
        else $error("access cycle without ready");
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench of the servo sync interrupt register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [ssir_pkg::ADDR_WIDTH-1:0] paddr_in = '0;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic vertical_drive_pulse_in = 1'b0;
    logic noise_event_in = 1'b0;
    logic ctl_event_in = 1'b0;
    ssir_pkg::ssir_settings_type settings_out;
    logic servo_irq_out;
    logic [15:0] lfsr = 16'h0043;
    logic [15:0] r;
    logic [31:0] rd;
    logic err;
    logic [1:0] fl, en;
    logic [7:0] val [6];
    int fails = 0;
    int checks_done = 0;
    localparam logic [15:0] EN = ssir_pkg::IDX_ENABLE_TWO;
    localparam logic [15:0] RQ = ssir_pkg::IDX_REQUEST_TWO;

    always #12.5 clk_in = ~clk_in;

    ssir_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .vertical_drive_pulse_in(vertical_drive_pulse_in),
        .noise_event_in(noise_event_in), .ctl_event_in(ctl_event_in),
        .settings_out(settings_out), .servo_irq_out(servo_irq_out));

    // ==========================================================
    // Helpers
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic [15:0] idx, input logic [1:0] low, input logic w,
        input logic [31:0] d);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= 20'({idx, low});
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic pulse(input logic [2:0] ev);
        {vertical_drive_pulse_in, noise_event_in, ctl_event_in} <= ev;
        @(posedge clk_in);
        {vertical_drive_pulse_in, noise_event_in, ctl_event_in} <= 3'h0;
        @(posedge clk_in);
    endtask

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        apb(EN, 2'h0, 1'b0, 32'h0);
        chk(rd, 36'hfc);
        apb(RQ, 2'h0, 1'b0, 32'h0);
        chk(rd, 36'hfc);
        chk(servo_irq_out, 36'h0);
        for (int i = 0; i < 6; i++) begin
            val[i] = 8'(rnd());
            apb(ssir_pkg::IDX_VERT_THRESHOLD + 16'(i), 2'h0, 1'b1, {24'h0, val[i]});
            apb(ssir_pkg::IDX_VERT_THRESHOLD + 16'(i), 2'h0, 1'b0, 32'h0);
            chk(rd, 36'h0);
        end
        chk(settings_out, {val[0][5:0], val[1][3:0], val[2], val[3][3:0], val[4][5:0], val[5]});
        apb(16'hd0b6, 2'h0, 1'b0, 32'h0);
        chk({err, rd}, {3'h0, 1'b1, 32'h0});
        apb(EN, 2'h1, 1'b1, 32'h3);
        chk(err, 36'h1);
        // CTL flag, masked then enabled, write one keeps it
        pulse(3'b001);
        apb(RQ, 2'h0, 1'b0, 32'h0);
        chk(rd, 36'hfd);
        chk(servo_irq_out, 36'h0);
        apb(EN, 2'h0, 1'b1, 32'h1);
        chk(servo_irq_out, 36'h1);
        apb(RQ, 2'h0, 1'b1, 32'hff);
        apb(RQ, 2'h0, 1'b0, 32'h0);
        chk(rd, 36'hfd);
        apb(EN, 2'h0, 1'b1, 32'h2);
        chk(servo_irq_out, 36'h0);
        pulse(3'b100);
        chk(servo_irq_out, 36'h1);
        apb(RQ, 2'h0, 1'b1, 32'hfc);
        apb(RQ, 2'h0, 1'b0, 32'h0);
        chk(rd, 36'hfc);
        pulse(3'b010);
        apb(RQ, 2'h0, 1'b0, 32'h0);
        chk(rd, 36'hfe);
        // CTL event exactly at the commit edge of a clearing write: the event wins
        fork
            apb(RQ, 2'h0, 1'b1, 32'h0);
            begin
                @(posedge clk_in);
                ctl_event_in <= 1'b1;
                @(posedge clk_in);
                ctl_event_in <= 1'b0;
            end
        join
        apb(RQ, 2'h0, 1'b0, 32'h0);
        chk(rd, 36'hfd);
        chk(servo_irq_out, 36'h0);
        fl = 2'h1;
        en = 2'h2;
        // Random events, enables and clearing writes against a local model
        for (int k = 0; k < 40; k++) begin
            r = rnd();
            pulse(r[2:0]);
            fl = fl | {r[2] | r[1], r[0]};
            apb(EN, 2'h0, 1'b1, {24'h0, r[10:3]});
            en = r[4:3];
            chk(servo_irq_out, {35'h0, |(fl & en)});
            apb(RQ, 2'h0, 1'b1, {24'h0, r[15:8]});
            fl = fl & r[9:8];
            apb(RQ, 2'h0, 1'b0, 32'h0);
            chk(rd, {28'h0, 6'h3f, fl});
            chk(servo_irq_out, {35'h0, |(fl & en)});
        end
        wrap_up();
    end

    initial begin
        #200000;
        fails++;
        $display("Error at %0t: timeout", $time);
        wrap_up();
    end
endmodule

bind ssir_regs ssir_regs_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .vertical_drive_pulse_in(vertical_drive_pulse_in),
    .noise_event_in(noise_event_in), .ctl_event_in(ctl_event_in),
    .servo_irq_out(servo_irq_out));
`default_nettype wire
